// ===== testbench/cpu_address_phase_interface_bench.sv
// Purpose: Joins both address-phase ends and drives cycles, snoops, floats and flushes.
// Assumes: Inputs change 1 ns after the rising edge.
// Notes: Every scenario judges its own results before returning.
`timescale 1ns/1ps
`default_nettype none
module cpu_address_phase_interface_bench;
   import addr_phase_pkg::*;
   logic sys_clk, nrst, req_valid, dual_mode, flush_cycle, req_ready, snoop_valid;
   logic parity_error, intc_enable, be4_in_n, snoop_req, snoop_bad_parity, float_hold;
   logic real_mode_a20, strap_intc_enable, flush_drive, flush_lane4_n, snoop_ready;
   logic cycle_seen, cycle_parity_ok, perr_seen;
   addr_type req_addr, lookup_addr, cycle_addr;
   be_type req_be, cycle_be;
   ctrl_type req_ctrl, cycle_ctrl;
   snoop_addr_type snoop_addr, snoop_req_addr;
   id_type intc_id, strap_intc_id;
   int bad_count = 0;
   int total_checks = 0;
   addr_phase_if bus_if();
   cpu_address_phase_interface cpu_address_phase_interface_i (.sys_clk(sys_clk), .nrst(nrst),
      .bus(bus_if.dev), .req_valid(req_valid), .req_addr(req_addr), .req_be(req_be),
      .req_ctrl(req_ctrl), .dual_mode(dual_mode), .flush_cycle(flush_cycle),
      .req_ready(req_ready), .lookup_addr(lookup_addr), .snoop_valid(snoop_valid),
      .snoop_addr(snoop_addr), .parity_error(parity_error), .intc_enable(intc_enable),
      .intc_id(intc_id), .be4_in_n(be4_in_n));
   system_address_phase_end system_address_phase_end_i (.sys_clk(sys_clk), .nrst(nrst),
      .bus(bus_if.host), .snoop_req(snoop_req), .snoop_req_addr(snoop_req_addr),
      .snoop_bad_parity(snoop_bad_parity), .float_hold(float_hold),
      .real_mode_a20(real_mode_a20), .strap_intc_enable(strap_intc_enable),
      .strap_intc_id(strap_intc_id), .flush_drive(flush_drive), .flush_lane4_n(flush_lane4_n),
      .snoop_ready(snoop_ready), .cycle_seen(cycle_seen), .cycle_addr(cycle_addr),
      .cycle_be(cycle_be), .cycle_ctrl(cycle_ctrl), .cycle_parity_ok(cycle_parity_ok),
      .perr_seen(perr_seen));
   cpu_address_phase_interface_props props_i (.sys_clk(sys_clk), .nrst(nrst),
      .dev_addr_oe(bus_if.dev_addr_oe), .dev_ap_oe(bus_if.dev_ap_oe),
      .host_addr_oe(bus_if.host_addr_oe), .phys_address_bus(bus_if.phys_address_bus),
      .address_parity_bit(bus_if.address_parity_bit), .dev_be_o(bus_if.dev_be_o),
      .dev_be_oe(bus_if.dev_be_oe), .dev_ads_oe(bus_if.dev_ads_oe),
      .cycle_start_strobe_n(bus_if.cycle_start_strobe_n),
      .cycle_start_strobe_dup_n(bus_if.cycle_start_strobe_dup_n),
      .address_float_request(bus_if.address_float_request),
      .external_snoop_strobe_n(bus_if.external_snoop_strobe_n),
      .address_parity_error_n(bus_if.address_parity_error_n));
   task automatic tick;
      @(posedge sys_clk);
      #1;
   endtask
   task automatic chk(input logic [63:0] seen, input logic [63:0] exp);
      total_checks++;
      if (seen !== exp) begin
         bad_count++;
         $display("[ERR] %0t seen %h exp %h", $time, seen, exp);
      end
   endtask
   task automatic final_report;
      if (bad_count == 0 && total_checks > 0) $display("[ PASS ]");
      else $display("[ FAIL ]");
      $finish;
   endtask
   // One cycle through the request port; mask and dual mode are set two clocks ahead.
   task automatic run_cycle(input addr_type a, input be_type be, input ctrl_type c,
                            input logic mask, input logic dual);
      addr_type e;
      int n;
      e = a;
      if (mask && !dual) e[20] = 1'b0;
      real_mode_a20 = mask;
      dual_mode = dual;
      req_addr = a;
      req_be = be;
      req_ctrl = c;
      repeat (2) tick;
      req_valid = 1'b1;
      n = 0;
      while (req_ready !== 1'b1 && n < 20) begin
         tick;
         n++;
      end
      tick;
      req_valid = 1'b0;
      n = 0;
      while (cycle_seen !== 1'b1 && n < 10) begin
         tick;
         n++;
      end
      chk(n < 10, 1);
      chk(cycle_addr, e);
      chk(lookup_addr, e);
      chk(cycle_be, be);
      chk(cycle_ctrl, c);
      chk(cycle_parity_ok, 1);
      chk(bus_if.dev_ctrl_oe, !dual);
      chk(bus_if.dev_ads_oe, !dual);
      real_mode_a20 = 1'b0;
      dual_mode = 1'b0;
   endtask
   task automatic t_back_to_back;
      int s;
      s = 0;
      req_addr = 29'h0ABCDEF1;
      req_valid = 1'b1;
      repeat (6) begin
         tick;
         if (bus_if.cycle_start_strobe_n === 1'b0) s++;
      end
      req_valid = 1'b0;
      chk(s, 3);
      repeat (3) tick;
   endtask
   task automatic t_snoop(input logic bad, input snoop_addr_type sa);
      int pe, ps, sv;
      pe = 0;
      ps = 0;
      sv = 0;
      snoop_req_addr = sa;
      snoop_bad_parity = bad;
      while (snoop_ready !== 1'b1 && pe < 10) begin
         tick;
         pe++;
      end
      pe = 0;
      snoop_req = 1'b1;
      tick;
      snoop_req = 1'b0;
      repeat (8) begin
         tick;
         if (parity_error === 1'b1) pe++;
         if (perr_seen === 1'b1) ps++;
         if (snoop_valid === 1'b1) begin
            sv++;
            chk(snoop_addr, sa);
         end
      end
      snoop_bad_parity = 1'b0;
      chk(sv, 1);
      chk(pe, bad);
      chk(ps, bad);
   endtask
   task automatic t_float;
      int cs;
      cs = 0;
      float_hold = 1'b1;
      repeat (3) tick;
      chk(bus_if.dev_addr_oe, 0);
      chk(req_ready, 0);
      req_valid = 1'b1;
      repeat (3) begin
         tick;
         if (cycle_seen === 1'b1) cs++;
      end
      chk(cs, 0);
      req_valid = 1'b0;
      float_hold = 1'b0;
      repeat (3) tick;
      chk(bus_if.dev_addr_oe, 1);
   endtask
   task automatic t_flush;
      dual_mode = 1'b1;
      flush_cycle = 1'b1;
      flush_drive = 1'b1;
      flush_lane4_n = 1'b0;
      repeat (3) tick;
      chk(be4_in_n, 0);
      flush_lane4_n = 1'b1;
      repeat (3) tick;
      chk(be4_in_n, 1);
      flush_drive = 1'b0;
      flush_cycle = 1'b0;
      dual_mode = 1'b0;
      repeat (2) tick;
   endtask
   initial begin
      sys_clk = 1'b0;
      forever #10 sys_clk = ~sys_clk;
   end
   initial begin
      #200000;
      bad_count++;
      final_report;
   end
   initial begin
      {nrst, req_valid, dual_mode, flush_cycle, snoop_req, snoop_bad_parity} = '0;
      {float_hold, real_mode_a20, flush_drive} = '0;
      req_addr = '0;
      req_be = 8'hFF;
      req_ctrl = 9'h00F;
      snoop_req_addr = '0;
      flush_lane4_n = 1'b1;
      strap_intc_enable = 1'b1;
      strap_intc_id = 4'hA;
      repeat (4) @(posedge sys_clk);
      #1;
      nrst = 1'b1;
      repeat (2) tick;
      chk(intc_enable, 1);
      chk(intc_id, 4'hA);
      chk(bus_if.address_parity_error_n, 1);
      run_cycle(29'h12345678, 8'hF0, 9'h1A5, 1'b0, 1'b0);
      run_cycle(29'h00120000, 8'h0F, 9'h0F0, 1'b1, 1'b0);
      run_cycle(29'h1FF20003, 8'h5A, 9'h10F, 1'b1, 1'b1);
      t_back_to_back;
      t_snoop(1'b0, 27'h5A5A5A5);
      t_snoop(1'b1, 27'h1234567);
      t_float;
      t_flush;
      final_report;
   end
endmodule
`default_nettype wire

// ===== testbench/cpu_address_phase_interface_props.sv
// Purpose: Timing relations on the address-phase link between the two ends.
// Assumes: One clock; nrst is synchronous and active low.
// Notes: Sits beside the interface and sees only its wires.
`timescale 1ns/1ps
`default_nettype none
module cpu_address_phase_interface_props (
   input wire logic sys_clk,
   input wire logic nrst,
   input wire logic dev_addr_oe,
   input wire logic dev_ap_oe,
   input wire logic host_addr_oe,
   input wire addr_phase_pkg::addr_type phys_address_bus,
   input wire logic address_parity_bit,
   input wire addr_phase_pkg::be_type dev_be_o,
   input wire addr_phase_pkg::be_type dev_be_oe,
   input wire logic dev_ads_oe,
   input wire logic cycle_start_strobe_n,
   input wire logic cycle_start_strobe_dup_n,
   input wire logic address_float_request,
   input wire logic external_snoop_strobe_n,
   input wire logic address_parity_error_n
);
   import addr_phase_pkg::*;
   default clocking cb @(posedge sys_clk);
   endclocking
   default disable iff (!nrst);
   strobe_dup_a: assert property (dev_ads_oe |->
      cycle_start_strobe_dup_n == cycle_start_strobe_n) else $error("Duplicate strobe differs.");
   strobe_single_a: assert property (!cycle_start_strobe_n |=>
      cycle_start_strobe_n) else $error("Cycle strobe longer than one clock.");
   float_off_a: assert property (address_float_request |=>
      !dev_addr_oe && !dev_ap_oe) else $error("Address still driven under float.");
   float_back_a: assert property ($fell(address_float_request) |=>
      dev_addr_oe && dev_ap_oe) else $error("Address not driven again after float.");
   float_lanes_a: assert property (address_float_request |=>
      $stable(dev_be_o)) else $error("Lanes disturbed by float.");
   even_parity_a: assert property (dev_addr_oe && dev_ap_oe |->
      !(^{phys_address_bus, address_parity_bit})) else $error("Address parity not even.");
   lanes_with_addr_a: assert property ($fell(cycle_start_strobe_n) |->
      dev_addr_oe && dev_ap_oe && dev_be_oe[3:0] == 4'hF) else $error("Lanes not with address.");
   snoop_addr_a: assert property (!external_snoop_strobe_n |->
      host_addr_oe && !dev_addr_oe && phys_address_bus[4:3] == 2'h0)
      else $error("Snoop address not driven by system.");
   perr_delay_a: assert property (!external_snoop_strobe_n &&
      (^{phys_address_bus, address_parity_bit}) |-> ##2 !address_parity_error_n)
      else $error("Parity error not flagged two clocks later.");
   perr_single_a: assert property (!address_parity_error_n |=>
      address_parity_error_n) else $error("Parity error longer than one clock.");
endmodule
`default_nettype wire

// ===== verilog/addr_phase_if.sv
// Purpose: Wires of the address phase between the processor end and the system end.
// Assumes: Each two-way pin is carried as output and enable from each driver.
// Notes: An undriven pin settles at its deasserted level, as a pull resistor would make it.
`timescale 1ns/1ps
`default_nettype none
`include "addr_phase_regs.svh"
interface addr_phase_if;
   import addr_phase_pkg::*;
   addr_type dev_addr_o;
   logic dev_addr_oe;
   addr_type host_addr_o;
   logic host_addr_oe;
   addr_type phys_address_bus;
   logic dev_ap_o;
   logic dev_ap_oe;
   logic host_ap_o;
   logic host_ap_oe;
   logic address_parity_bit;
   be_type dev_be_o;
   be_type dev_be_oe;
   be_type host_be_o;
   be_type host_be_oe;
   be_type byte_lane_selects_n;
   logic dev_ads_n_o;
   logic dev_ads_oe;
   logic cycle_start_strobe_n;
   logic cycle_start_strobe_dup_n;
   ctrl_type dev_ctrl_o;
   logic dev_ctrl_oe;
   ctrl_type ctrl_pins;
   logic address_float_request;
   logic addr_bit20_mask_n;
   logic external_snoop_strobe_n;
   logic local_intc_enable_strap;
   logic address_parity_error_n;
   assign phys_address_bus = dev_addr_oe ? dev_addr_o :
                             (host_addr_oe ? host_addr_o : `ADDR_IDLE);
   assign address_parity_bit = dev_ap_oe ? dev_ap_o : (host_ap_oe ? host_ap_o : 1'b1);
   assign byte_lane_selects_n = (dev_be_oe & dev_be_o) | (~dev_be_oe & host_be_oe & host_be_o)
                                | (~dev_be_oe & ~host_be_oe);
   assign cycle_start_strobe_n = dev_ads_oe ? dev_ads_n_o : 1'b1;
   assign ctrl_pins = dev_ctrl_oe ? dev_ctrl_o : `CTRL_IDLE;
   modport dev (
      output dev_addr_o, dev_addr_oe, dev_ap_o, dev_ap_oe, dev_be_o, dev_be_oe,
      output dev_ads_n_o, dev_ads_oe, cycle_start_strobe_dup_n, dev_ctrl_o, dev_ctrl_oe,
      output address_parity_error_n,
      input phys_address_bus, address_parity_bit, byte_lane_selects_n,
      input address_float_request, addr_bit20_mask_n, external_snoop_strobe_n,
      input local_intc_enable_strap
   );
   modport host (
      output host_addr_o, host_addr_oe, host_ap_o, host_ap_oe, host_be_o, host_be_oe,
      output address_float_request, addr_bit20_mask_n, external_snoop_strobe_n,
      output local_intc_enable_strap,
      input phys_address_bus, address_parity_bit, byte_lane_selects_n,
      input cycle_start_strobe_n, cycle_start_strobe_dup_n, ctrl_pins,
      input address_parity_error_n
   );
endinterface
`default_nettype wire

// ===== verilog/addr_phase_pkg.sv
// Purpose: Types, state encodings and the two shared parity functions of the address phase.
// Assumes: The link and both ends run on the one bus clock.
// Notes: Reset images of each end's state are kept here beside the types.
`include "addr_phase_regs.svh"
package addr_phase_pkg;
   typedef logic [`ADDR_MSB:`ADDR_LSB] addr_type;
   typedef logic [`ADDR_MSB:`SNOOP_LSB] snoop_addr_type;
   typedef logic [`BE_MSB:0] be_type;
   typedef logic [`ID_MSB:0] id_type;
   typedef logic [`CTRL_MSB:0] ctrl_type;
   typedef enum logic [2:0] {
      DEV_RESET = 3'h1,
      DEV_IDLE = 3'h2,
      DEV_DRIVE = 3'h4
   } dev_state_type;
   typedef enum logic [2:0] {
      HOST_IDLE = 3'h1,
      HOST_FLOAT = 3'h2,
      HOST_SNOOP = 3'h4
   } host_state_type;
   typedef struct packed {
      dev_state_type state;
      addr_type addr;
      logic addr_oe;
      logic ap;
      be_type be;
      be_type be_oe;
      ctrl_type ctrl;
      logic ctrl_oe;
      logic ads_n;
      logic ads_oe;
      logic req_ready;
      addr_type lookup_addr;
      logic [`ADDRESS_PARITY_ERROR_N_DELAY-2:0] err_pipe;
      logic perr_n;
      logic snoop_valid;
      snoop_addr_type snoop_addr;
      logic intc_enable;
      id_type intc_id;
      logic be4_in;
   } dev_regs_type;
   typedef struct packed {
      host_state_type state;
      snoop_addr_type snoop_addr;
      logic bad_parity;
      addr_type addr;
      logic addr_oe;
      logic ap;
      logic external_snoop_strobe_n_n;
      logic float_req;
      logic a20_mask_n;
      logic id_drive;
      be_type be_o;
      be_type be_oe;
      logic strap_o;
      logic snoop_ready;
      logic cycle_seen;
      addr_type cycle_addr;
      be_type cycle_be;
      ctrl_type cycle_ctrl;
      logic cycle_parity_ok;
      logic perr_seen;
   } host_regs_type;
   localparam dev_regs_type DEV_RST = '{
      state: DEV_RESET, addr: `ADDR_IDLE, addr_oe: 1'b0, ap: 1'b1, be: `LANES_IDLE,
      be_oe: '0, ctrl: `CTRL_IDLE, ctrl_oe: 1'b0, ads_n: 1'b1, ads_oe: 1'b0,
      req_ready: 1'b0, lookup_addr: '0, err_pipe: '0, perr_n: 1'b1, snoop_valid: 1'b0,
      snoop_addr: '0, intc_enable: 1'b0, intc_id: '0, be4_in: 1'b1};
   localparam host_regs_type HOST_RST = '{
      state: HOST_IDLE, snoop_addr: '0, bad_parity: 1'b0, addr: `ADDR_IDLE, addr_oe: 1'b0,
      ap: 1'b0, external_snoop_strobe_n_n: 1'b1, float_req: 1'b0, a20_mask_n: 1'b1, id_drive: 1'b1,
      be_o: `LANES_IDLE, be_oe: '0, strap_o: 1'b0, snoop_ready: 1'b0, cycle_seen: 1'b0,
      cycle_addr: '0, cycle_be: `LANES_IDLE, cycle_ctrl: `CTRL_IDLE,
      cycle_parity_ok: 1'b0, perr_seen: 1'b0};
   // Even parity bit for an address: makes the address plus bit hold an even count of ones.
   function automatic logic even_parity(input addr_type a);
      return ^a;
   endfunction
   // True when an address and its parity bit together hold an odd count of ones.
   function automatic logic parity_bad(input addr_type a, input logic p);
      return ^{a, p};
   endfunction
endpackage

// ===== verilog/addr_phase_regs.svh
// Purpose: Named positions, widths, idle levels and delays of the address-phase pins.
// Assumes: Included by the package, the interface and both ends; definitions only.
// Notes: Control pin order: 0 cache_n, 1 snoop_hit_n, 2 snoop_hit_modified_n, 3 lock_n,
// Notes: 4 hold_acknowledge, 5 mem_io, 6 data_code, 7 write_read, 8 split_cycle_flag.
`ifndef ADDR_PHASE_REGS_SVH
`define ADDR_PHASE_REGS_SVH
`define ADDR_MSB 31
`define ADDR_LSB 3
`define SNOOP_LSB 5
`define SNOOP_PAD 2'h0
`define A20_POS 20
`define BE_MSB 7
`define ID_MSB 3
`define BE_FLUSH_POS 4
`define CTRL_MSB 8
`define CTRL_IDLE 9'h00F
`define ADDRESS_PARITY_ERROR_N_DELAY 2
`define LANES_IDLE 8'hFF
`define ADDR_IDLE 29'h1FFFFFFF
`endif

// ===== verilog/cpu_address_phase_interface.sv
// Purpose: Processor end of the address phase: drives cycles, floats on request, checks snoops.
// Assumes: All link pins are on sys_clk, so they are sampled without synchronisers.
// Notes: One cycle is driven at a time; the strobe stands for exactly one clock per cycle.
//
// Contract
// RULE_01: Bit-20 mask forces address bit 20 low.
// RULE_02: System asserts bit-20 mask only in real mode.
// RULE_03: Dual processor ignores the bit-20 mask input.
// RULE_04: Device drives PHYS_ADDRESS_BUS; system drives snoop A31-A5.
// RULE_05: Cycle-start strobe and duplicate mark new cycles.
// RULE_06: Float request stops address and parity next clock.
// RULE_07: Other bus signals stay active while floated.
// RULE_08: Even address parity driven with the address.
// RULE_09: System drives even parity with snoop strobe.
// RULE_10: Parity error output two clocks after snoop strobe.
// RULE_11: Parity error output lasts one clock each.
// RULE_12: Interrupt controller enable strap sampled leaving reset.
// RULE_13: Active-low byte-lane selects driven with address.
// RULE_14: Low four lanes give identifier at reset.
// RULE_15: Dual mode: lane four is input during flush.
// RULE_16: Dual mode: strobe and control pins become two-way.
// RULE_17: Names ending _n are asserted low.
// RULE_18: Even parity covers PHYS_ADDRESS_BUS plus parity bit.
`timescale 1ns/1ps
`default_nettype none
`include "addr_phase_regs.svh"
module cpu_address_phase_interface (
   input wire logic sys_clk,
   input wire logic nrst,
   addr_phase_if.dev bus,
   input wire logic req_valid,
   input wire addr_phase_pkg::addr_type req_addr,
   input wire addr_phase_pkg::be_type req_be,
   input wire addr_phase_pkg::ctrl_type req_ctrl,
   input wire logic dual_mode,
   input wire logic flush_cycle,
   output logic req_ready,
   output addr_phase_pkg::addr_type lookup_addr,
   output logic snoop_valid,
   output addr_phase_pkg::snoop_addr_type snoop_addr,
   output logic parity_error,
   output logic intc_enable,
   output addr_phase_pkg::id_type intc_id,
   output logic be4_in_n
);
   import addr_phase_pkg::*;

   dev_regs_type q;
   dev_regs_type d;
   addr_type masked_addr;
   logic mask_active;
   logic snoop_err;
   logic take_req;

   always_comb begin
      d = q;
      // The mask pin is only honoured on the first processor; the dual one drops it internally.
      mask_active = ~bus.addr_bit20_mask_n & ~dual_mode; // RULE_01 RULE_03 RULE_17
      masked_addr = req_addr;
      if (mask_active) begin
         masked_addr[`A20_POS] = 1'b0; // RULE_01
      end
      // Cache lookups see the same wrapped address that the bus would.
      d.lookup_addr = masked_addr; // RULE_01
      // Snoop check: the address and parity are taken in the clock the strobe is low.
      snoop_err = ~bus.external_snoop_strobe_n
                  & parity_bad(bus.phys_address_bus, bus.address_parity_bit); // RULE_18 RULE_09
      d.snoop_valid = ~bus.external_snoop_strobe_n; // RULE_04
      if (~bus.external_snoop_strobe_n) begin
         d.snoop_addr = bus.phys_address_bus[`ADDR_MSB:`SNOOP_LSB]; // RULE_04
      end
      // The sampling flop and the output flop make up the two clocks; each error gives one low clock.
      d.err_pipe = snoop_err; // RULE_10
      d.perr_n = ~q.err_pipe[`ADDRESS_PARITY_ERROR_N_DELAY-2]; // RULE_10 RULE_11
      // Address and parity let go one clock after the float request is seen.
      d.addr_oe = ~bus.address_float_request; // RULE_06
      // Strobe, lanes and control stay driven under float so earlier cycles can finish.
      take_req = 1'b0;
      case (q.state)
         DEV_RESET: begin
            // First edge after reset release: the straps are still on the pins.
            d.intc_enable = bus.local_intc_enable_strap; // RULE_12
            d.intc_id = bus.byte_lane_selects_n[`ID_MSB:0]; // RULE_14
            d.state = DEV_IDLE;
         end
         DEV_IDLE: begin
            take_req = req_valid & q.req_ready & ~bus.address_float_request;
            if (take_req) begin
               d.state = DEV_DRIVE;
               d.addr = masked_addr; // RULE_01 RULE_04
               d.ap = even_parity(masked_addr); // RULE_08 RULE_18
               d.be = req_be; // RULE_13
               d.ctrl = req_ctrl;
               d.ads_n = 1'b0; // RULE_05
            end
         end
         DEV_DRIVE: begin
            d.state = DEV_IDLE;
            d.ads_n = 1'b1; // RULE_05
         end
         default: begin
            d.state = DEV_IDLE;
            d.ads_n = 1'b1;
         end
      endcase
      // In dual mode the strobe and control pins are only driven during the owned cycle.
      if (dual_mode) begin
         d.ads_oe = (d.state == DEV_DRIVE); // RULE_16
         d.ctrl_oe = (d.state == DEV_DRIVE); // RULE_16
      end else begin
         d.ads_oe = 1'b1; // RULE_07
         d.ctrl_oe = 1'b1; // RULE_07
      end
      d.be_oe = '1; // RULE_13 RULE_14
      if (dual_mode & flush_cycle) begin
         d.be_oe[`BE_FLUSH_POS] = 1'b0; // RULE_15
      end
      if (dual_mode & flush_cycle) begin
         d.be4_in = bus.byte_lane_selects_n[`BE_FLUSH_POS]; // RULE_15
      end
      d.req_ready = (d.state == DEV_IDLE) & ~bus.address_float_request;
   end

   always_ff @(posedge sys_clk) begin
      if (!nrst) begin
         q <= DEV_RST;
      end else begin
         q <= d;
      end
   end

   assign bus.dev_addr_o = q.addr;
   assign bus.dev_addr_oe = q.addr_oe;
   assign bus.dev_ap_o = q.ap;
   assign bus.dev_ap_oe = q.addr_oe;
   assign bus.dev_be_o = q.be;
   assign bus.dev_be_oe = q.be_oe;
   assign bus.dev_ads_n_o = q.ads_n;
   assign bus.dev_ads_oe = q.ads_oe;
   assign bus.cycle_start_strobe_dup_n = q.ads_n; // RULE_05
   assign bus.dev_ctrl_o = q.ctrl;
   assign bus.dev_ctrl_oe = q.ctrl_oe;
   assign bus.address_parity_error_n = q.perr_n;
   assign req_ready = q.req_ready;
   assign lookup_addr = q.lookup_addr;
   assign snoop_valid = q.snoop_valid;
   assign snoop_addr = q.snoop_addr;
   assign parity_error = ~q.perr_n;
   assign intc_enable = q.intc_enable;
   assign intc_id = q.intc_id;
   assign be4_in_n = q.be4_in;
endmodule
`default_nettype wire

// ===== verilog/system_address_phase_end.sv
// Purpose: System end of the address phase: runs snoops, drives straps, watches cycles.
// Assumes: Same sys_clk as the processor end; user requests are single-cycle pulses.
// Notes: A snoop always raises the float request itself one clock before driving the bus.
`timescale 1ns/1ps
`default_nettype none
`include "addr_phase_regs.svh"
module system_address_phase_end (
   input wire logic sys_clk,
   input wire logic nrst,
   addr_phase_if.host bus,
   input wire logic snoop_req,
   input wire addr_phase_pkg::snoop_addr_type snoop_req_addr,
   input wire logic snoop_bad_parity,
   input wire logic float_hold,
   input wire logic real_mode_a20,
   input wire logic strap_intc_enable,
   input wire addr_phase_pkg::id_type strap_intc_id,
   input wire logic flush_drive,
   input wire logic flush_lane4_n,
   output logic snoop_ready,
   output logic cycle_seen,
   output addr_phase_pkg::addr_type cycle_addr,
   output addr_phase_pkg::be_type cycle_be,
   output addr_phase_pkg::ctrl_type cycle_ctrl,
   output logic cycle_parity_ok,
   output logic perr_seen
);
   import addr_phase_pkg::*;

   host_regs_type q;
   host_regs_type d;

   always_comb begin
      d = q;
      d.a20_mask_n = ~real_mode_a20; // RULE_02 RULE_17
      d.id_drive = 1'b0;
      d.strap_o = strap_intc_enable; // RULE_12
      d.be_o = `LANES_IDLE;
      d.be_o[`ID_MSB:0] = strap_intc_id; // RULE_14
      d.be_o[`BE_FLUSH_POS] = flush_lane4_n; // RULE_15
      d.be_oe = '0;
      d.be_oe[`BE_FLUSH_POS] = flush_drive; // RULE_15
      case (q.state)
         HOST_IDLE: begin
            if (snoop_req) begin
               d.state = HOST_FLOAT;
               d.snoop_addr = snoop_req_addr;
               d.bad_parity = snoop_bad_parity;
            end
         end
         HOST_FLOAT: begin
            d.state = HOST_SNOOP;
            d.addr = {q.snoop_addr, `SNOOP_PAD}; // RULE_04
            d.ap = even_parity({q.snoop_addr, `SNOOP_PAD}) ^ q.bad_parity; // RULE_09 RULE_18
            d.addr_oe = 1'b1;
            d.external_snoop_strobe_n_n = 1'b0; // RULE_09
         end
         HOST_SNOOP: begin
            d.state = HOST_IDLE;
            d.addr_oe = 1'b0;
            d.external_snoop_strobe_n_n = 1'b1;
         end
         default: begin
            d.state = HOST_IDLE;
            d.addr_oe = 1'b0;
            d.external_snoop_strobe_n_n = 1'b1;
         end
      endcase
      d.float_req = float_hold | (d.state != HOST_IDLE); // RULE_06
      d.snoop_ready = (d.state == HOST_IDLE);
      d.cycle_seen = ~bus.cycle_start_strobe_n; // RULE_05
      if (~bus.cycle_start_strobe_n) begin
         d.cycle_addr = bus.phys_address_bus;
         d.cycle_be = bus.byte_lane_selects_n; // RULE_13
         d.cycle_ctrl = bus.ctrl_pins;
         d.cycle_parity_ok = ~parity_bad(bus.phys_address_bus, bus.address_parity_bit); // RULE_08
      end
      d.perr_seen = ~bus.address_parity_error_n; // RULE_11
   end

   // The strap values must be on the pins during reset, so those fields follow the inputs.
   always_ff @(posedge sys_clk) begin
      if (!nrst) begin
         q <= HOST_RST;
         q.be_o <= d.be_o;
         q.strap_o <= d.strap_o;
      end else begin
         q <= d;
      end
   end

   assign bus.host_addr_o = q.addr;
   assign bus.host_addr_oe = q.addr_oe;
   assign bus.host_ap_o = q.ap;
   assign bus.host_ap_oe = q.addr_oe;
   assign bus.host_be_o = q.be_o;
   assign bus.host_be_oe = q.be_oe | {{(`BE_MSB-`ID_MSB){1'b0}}, {(`ID_MSB+1){q.id_drive}}};
   assign bus.address_float_request = q.float_req;
   assign bus.addr_bit20_mask_n = q.a20_mask_n;
   assign bus.external_snoop_strobe_n = q.external_snoop_strobe_n_n;
   assign bus.local_intc_enable_strap = q.strap_o;
   assign snoop_ready = q.snoop_ready;
   assign cycle_seen = q.cycle_seen;
   assign cycle_addr = q.cycle_addr;
   assign cycle_be = q.cycle_be;
   assign cycle_ctrl = q.cycle_ctrl;
   assign cycle_parity_ok = q.cycle_parity_ok;
   assign perr_seen = q.perr_seen;
endmodule
`default_nettype wire
